// [dv/cpu_core_registers_props.sv]
`timescale 1ns/10ps
// Port-level checker for the core register set
module cpu_core_props
  import cpu_core_pkg::*;
(
  input  wire logic        sys_clk,                 // CPU clock
  input  wire logic        rst,                     // Synchronous reset
  input  wire logic        op_valid,                // Request strobe
  input  op_type           op,                      // Operation code
  input  wire logic [7:0]  data_in,                 // Operand
  input  wire logic [1:0]  source_priority_setting, // Serviced source level
  input  wire logic [7:0]  acc,                     // Accumulator
  input  wire logic [7:0]  index_y,                 // Second index register
  input  wire logic [7:0]  condition_flags,         // Flags
  input  wire logic [15:0] stack_pointer,           // Stack pointer
  input  wire logic [15:0] mem_addr,                // Stack address
  input  wire logic        mem_write,               // Stack write strobe
  input  wire logic        mem_read,                // Stack read strobe
  input  wire logic        busy                     // Sequence running
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  logic       take;     // Request accepted this edge
  logic [8:0] sum_exp;  // Sum with carry, one cycle late
  logic       half_exp; // Carry out of bit 3, one cycle late

  assign take = op_valid && !busy;

  // Predicted add result, registered so it lines up with the answer
  always_ff @(posedge sys_clk) begin
    sum_exp  <= {1'b0, acc} + {1'b0, data_in};
    half_exp <= ({1'b0, acc[3:0]} + {1'b0, data_in[3:0]}) > 5'h0f;
  end

  property p_sp_page; stack_pointer[15:8] == 8'h01; endproperty
  a_sp_page: assert property (p_sp_page) else $error("stack page left 01");
  property p_flags_top; condition_flags[7:6] == 2'b11; endproperty
  a_flags_top: assert property (p_flags_top) else $error("flag bits 7:6 not one");
  property p_reset_vals; $past(rst) |-> stack_pointer == 16'h01ff && (condition_flags & 8'he8) == 8'he8; endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad state after reset");
  property p_add; take && op == OP_ADD |=> acc == sum_exp[7:0] && condition_flags[4] == half_exp
    && condition_flags[0] == sum_exp[8]; endproperty
  a_add: assert property (p_add) else $error("add result or carries wrong");
  property p_nz; take && (op == OP_ADD || op == OP_LOAD_A) |=> condition_flags[2] == acc[7]
    && condition_flags[1] == (acc == 8'h00); endproperty
  a_nz: assert property (p_nz) else $error("sign or zero flag wrong");
  property p_carry_force; take && (op == OP_SET_CARRY || op == OP_RESET_CARRY)
    |=> condition_flags[0] == ($past(op) == OP_SET_CARRY); endproperty
  a_carry_force: assert property (p_carry_force) else $error("carry not forced");
  property p_push_addr; mem_write |-> mem_addr == {8'h01, stack_pointer[7:0] + 8'h01}; endproperty
  a_push_addr: assert property (p_push_addr) else $error("push address off");
  property p_pop_addr; mem_read |-> mem_addr == stack_pointer && $changed(stack_pointer); endproperty
  a_pop_addr: assert property (p_pop_addr) else $error("pop address off");
  property p_irq_prio; take && op == OP_IRQ_ENTRY |=> busy ##[1:12]
    ($fell(busy) && {condition_flags[5], condition_flags[3]} == source_priority_setting); endproperty
  a_irq_prio: assert property (p_irq_prio) else $error("entry priority not loaded");
  property p_y_kept; busy |-> $stable(index_y); endproperty
  a_y_kept: assert property (p_y_kept) else $error("second index moved in sequence");
  property p_rsp; take && op == OP_RESET_SP |=> stack_pointer == 16'h01ff; endproperty
  a_rsp: assert property (p_rsp) else $error("stack reset failed");
  property p_ld_sp; take && op == OP_LOAD_SP_LOW |=> stack_pointer == {8'h01, $past(data_in)}; endproperty
  a_ld_sp: assert property (p_ld_sp) else $error("stack low load failed");
endmodule : cpu_core_props

bind cpu_core_registers cpu_core_props cpu_core_props_inst (
  .sys_clk(sys_clk), .rst(rst), .op_valid(op_valid), .op(op), .data_in(data_in),
  .source_priority_setting(source_priority_setting), .acc(acc), .index_y(index_y),
  .condition_flags(condition_flags), .stack_pointer(stack_pointer), .mem_addr(mem_addr),
  .mem_write(mem_write), .mem_read(mem_read), .busy(busy));

// [dv/tb_top.sv]
`timescale 1ns/10ps
// Compare and count; an unknown never passes
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin errors++; \
  $display("unexpected at %0t: value %h, wanted %h", $time, (got), (exp)); end end

module tb_top
  import cpu_core_pkg::*;
;
  logic        sys_clk, rst, op_valid, carry_in;      // Clock, reset, strobes
  op_type      op;                                   // Operation code
  logic [7:0]  data_in, mem_rdata, acc, index_x, index_y, condition_flags, mem_wdata, cc_save;
  logic [15:0] target_addr, program_counter, stack_pointer, mem_addr;
  logic [1:0]  source_priority_setting;              // Source level
  logic        mem_write, mem_read, busy;            // Stack strobes
  logic [7:0]  stack_mem [0:255];                    // Stack page model
  logic [7:0]  wr_log [$];                           // Pushed bytes in order
  logic [7:0]  add_a [3] = '{8'h0f, 8'h80, 8'h7f};   // Half carry, carry, sign cases
  logic [7:0]  add_b [3] = '{8'h01, 8'h80, 8'h01};
  logic [8:0]  sum;                                  // Expected sum
  int          errors, n_checks;                     // Report counters

  cpu_core_registers cpu_core_registers_inst (.sys_clk(sys_clk), .rst(rst), .op_valid(op_valid), .op(op),
    .data_in(data_in), .carry_in(carry_in), .target_addr(target_addr),
    .source_priority_setting(source_priority_setting), .mem_rdata(mem_rdata), .acc(acc), .index_x(index_x),
    .index_y(index_y), .program_counter(program_counter), .condition_flags(condition_flags),
    .stack_pointer(stack_pointer), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_write(mem_write),
    .mem_read(mem_read), .busy(busy));

  // Stack memory answers reads without a clock, as the core expects
  assign mem_rdata = stack_mem[mem_addr[7:0]];
  always @(posedge sys_clk) begin
    if (mem_write === 1'b1) begin
      stack_mem[mem_addr[7:0]] <= mem_wdata;
      wr_log.push_back(mem_wdata);
    end
  end

  // 40 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run

  // One request, then wait out any stack sequence plus one cycle so the last byte is logged
  task automatic do_op(input op_type o, input logic [7:0] d);
    op = o;
    data_in = d;
    op_valid = 1'b1;
    @(posedge sys_clk); #1;
    op_valid = 1'b0;
    for (int i = 0; i < 40 && busy !== 1'b0; i++) begin
      @(posedge sys_clk); #1;
    end
    @(posedge sys_clk); #1;
  endtask : do_op

  // Watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    errors++;
    $display("unexpected at %0t: run hung", $time);
    complete_run();
  end

  // Main sequence
  initial begin
    rst = 1'b1; op_valid = 1'b0; op = OP_NONE; data_in = 8'h00; carry_in = 1'b0;
    target_addr = 16'h0000; source_priority_setting = 2'b00;
    repeat (16) @(posedge sys_clk);
    #1 rst = 1'b0;
    `CHK(condition_flags & 8'he8, 8'he8)
    `CHK(stack_pointer, 16'h01ff)
    // Adds across the half-carry, carry and sign boundaries
    for (int i = 0; i < 3; i++) begin
      do_op(OP_LOAD_A, add_a[i]);
      do_op(OP_ADD, add_b[i]);
      sum = {1'b0, add_a[i]} + {1'b0, add_b[i]};
      `CHK(acc, sum[7:0])
      `CHK(condition_flags[4], ({1'b0, add_a[i][3:0]} + {1'b0, add_b[i][3:0]}) > 5'h0f)
      `CHK(condition_flags[2], sum[7])
      `CHK(condition_flags[1], sum[7:0] == 8'h00)
      `CHK(condition_flags[0], sum[8])
    end
    // Subtract: borrow lands in carry, then a zero result with no borrow
    do_op(OP_LOAD_A, 8'h10);
    do_op(OP_SUB, 8'h20);
    `CHK({acc, condition_flags[2], condition_flags[0]}, {8'hf0, 1'b1, 1'b1})
    do_op(OP_SUB, 8'hf0);
    `CHK({acc, condition_flags[1], condition_flags[0]}, {8'h00, 1'b1, 1'b0})
    do_op(OP_SET_CARRY, 8'h00);
    `CHK(condition_flags[0], 1'b1)
    do_op(OP_LOAD_A, 8'h0e);
    do_op(OP_ADC, 8'h01);
    `CHK(acc, 8'h10)
    `CHK(condition_flags[4], 1'b1)
    // Carry is set first so that the reset really has to clear it
    do_op(OP_SET_CARRY, 8'h00);
    do_op(OP_RESET_CARRY, 8'h00);
    `CHK(condition_flags[0], 1'b0)
    carry_in = 1'b1;
    do_op(OP_SHIFT, 8'h40);
    `CHK(condition_flags[0], 1'b1)
    carry_in = 1'b0;
    // Bit test takes its carry from outside, here clearing it
    do_op(OP_BIT_TEST, 8'h00);
    `CHK(condition_flags[0], 1'b0)
    // Every priority level
    for (int l = 0; l < 4; l++) begin
      do_op(OP_SET_PRIORITY, 8'(l));
      `CHK({condition_flags[5], condition_flags[3]}, 2'(l))
    end
    // Single-bit control of the half-carry bit
    do_op(OP_FLAG_BIT, 8'h0c);
    `CHK(condition_flags[4], 1'b1)
    do_op(OP_FLAG_BIT, 8'h04);
    `CHK(condition_flags[4], 1'b0)
    // Clearing a fixed top bit is refused
    do_op(OP_FLAG_BIT, 8'h06);
    `CHK(condition_flags[7:6], 2'b11)
    // Push below the page bottom wraps, pop wraps back
    do_op(OP_LOAD_A, 8'h5a);
    do_op(OP_LOAD_SP_LOW, 8'h00);
    `CHK(stack_pointer, 16'h0100)
    do_op(OP_PUSH_A, 8'h00);
    `CHK(stack_pointer, 16'h01ff)
    `CHK(stack_mem[8'h00], 8'h5a)
    do_op(OP_LOAD_A, 8'h00);
    do_op(OP_POP_A, 8'h00);
    `CHK(stack_pointer, 16'h0100)
    `CHK(acc, 8'h5a)
    do_op(OP_RESET_SP, 8'h00);
    `CHK(stack_pointer, 16'h01ff)
    // Call and return
    target_addr = 16'habcd;
    do_op(OP_JUMP, 8'h00);
    `CHK(program_counter, 16'habcd)
    wr_log.delete();
    target_addr = 16'h1234;
    do_op(OP_CALL, 8'h00);
    `CHK(wr_log.size(), 2)
    `CHK({wr_log[1], wr_log[0]}, 16'habcd)
    `CHK(stack_pointer, 16'h01fd)
    `CHK(program_counter, 16'h1234)
    do_op(OP_RET, 8'h00);
    `CHK(program_counter, 16'habcd)
    `CHK(stack_pointer, 16'h01ff)
    // Interrupt entry and return
    do_op(OP_LOAD_X, 8'h11);
    do_op(OP_LOAD_Y, 8'h22);
    do_op(OP_LOAD_A, 8'h33);
    do_op(OP_SET_PRIORITY, 8'h02);
    cc_save = condition_flags;
    wr_log.delete();
    target_addr = 16'h4000;
    source_priority_setting = 2'b01;
    do_op(OP_IRQ_ENTRY, 8'h00);
    `CHK(wr_log.size(), 5)
    `CHK({wr_log[0], wr_log[1], wr_log[2], wr_log[3], wr_log[4]}, {8'hcd, 8'hab, 8'h11, 8'h33, cc_save})
    `CHK(stack_mem[8'hff], 8'hcd)
    `CHK(stack_pointer, 16'h01fa)
    `CHK({program_counter, condition_flags[5], condition_flags[3]}, {16'h4000, 2'b01})
    `CHK(index_y, 8'h22)
    do_op(OP_LOAD_A, 8'h00);
    do_op(OP_LOAD_X, 8'h00);
    do_op(OP_RETURN_FROM_INTERRUPT_INSTR, 8'h00);
    `CHK({acc, index_x, program_counter}, {8'h33, 8'h11, 16'habcd})
    `CHK(condition_flags, cc_save)
    `CHK(stack_pointer, 16'h01ff)
    `CHK(index_y, 8'h22)
    // Single pushes and pops; flags and priority come back from the stack
    do_op(OP_PUSH_X, 8'h00);
    do_op(OP_PUSH_Y, 8'h00);
    do_op(OP_PUSH_CC, 8'h00);
    do_op(OP_SET_PRIORITY, 8'h03);
    `CHK(stack_pointer, 16'h01fc)
    do_op(OP_POP_CC, 8'h00);
    do_op(OP_POP_X, 8'h00);
    do_op(OP_POP_Y, 8'h00);
    `CHK({condition_flags, index_x, index_y, stack_pointer}, {cc_save, 8'h22, 8'h11, 16'h01ff})
    // Reset in mid-run brings the whole register set back
    rst = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 rst = 1'b0;
    `CHK({acc, index_x, index_y, program_counter}, {8'h00, 8'h00, 8'h00, 16'h0000})
    `CHK({stack_pointer, condition_flags, busy}, {16'h01ff, 8'he8, 1'b0})
    complete_run();
  end
endmodule : tb_top

// [include/cpu_core_pkg.sv]
package cpu_core_pkg;

  // Operations presented by the instruction sequencer
  typedef enum logic [4:0] {
    OP_NONE, OP_LOAD_A, OP_LOAD_X, OP_LOAD_Y, OP_ADD, OP_ADC, OP_SUB, OP_SHIFT,
    OP_BIT_TEST, OP_SET_CARRY, OP_RESET_CARRY, OP_SET_PRIORITY, OP_FLAG_BIT,
    OP_JUMP, OP_LOAD_SP_LOW, OP_RESET_SP, OP_PUSH_A, OP_PUSH_X, OP_PUSH_Y,
    OP_PUSH_CC, OP_POP_A, OP_POP_X, OP_POP_Y, OP_POP_CC, OP_CALL, OP_RET,
    OP_IRQ_ENTRY, OP_RETURN_FROM_INTERRUPT_INSTR
  } op_type;

  // Stack sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE, SEQ_PUSH, SEQ_POP_ISSUE, SEQ_POP_TAKE
  } seq_type;

  // Whole register-set state
  typedef struct packed {
    logic [7:0]  acc;
    logic [7:0]  index_x;
    logic [7:0]  index_y;
    logic [15:0] program_counter;
    logic [7:0]  condition_flags;
    logic [15:0] stack_pointer;
    seq_type     seq;
    op_type      op;
    logic [2:0]  step;
    logic [15:0] jump_target;
    logic [15:0] mem_addr;
    logic [7:0]  mem_wdata;
    logic        mem_write;
    logic        mem_read;
    logic        busy;
  } state_type;

endpackage : cpu_core_pkg

// [include/cpu_core_regs.svh]
`ifndef CPU_CORE_REGS_SVH
`define CPU_CORE_REGS_SVH

// Flag bit positions inside condition_flags
`define FLAG_CARRY       3'd0
`define FLAG_ZERO        3'd1
`define FLAG_NEGATIVE    3'd2
`define FLAG_PRIO_LOW    3'd3
`define FLAG_HALF        3'd4
`define FLAG_PRIO_HIGH   3'd5

// Reset values; undefined flag bits come up as zero
`define CC_RESET         8'he8
`define CC_FIXED_ONES    8'hc0
`define ACC_RESET        8'h00
`define INDEX_RESET      8'h00
`define PC_RESET         16'h0000
`define SP_HIGH          8'h01
`define SP_LOW_RESET     8'hff
`define SP_RESET         16'h01ff

// Priority encodings held in priority_bit_high/priority_bit_low
`define PRIO_LEVEL0      2'h2
`define PRIO_LEVEL1      2'h1
`define PRIO_LEVEL2      2'h0
`define PRIO_DISABLED    2'h3

// Stack bytes per frame
`define FRAME_IRQ        3'h5
`define FRAME_CALL       3'h2
`define FRAME_SINGLE     3'h1

`endif

// [src/cpu_core_registers.sv]
`timescale 1ns/10ps
`include "cpu_core_regs.svh"
// How it works
// - 8-bit accumulator holds operands and results
// - Two 8-bit index registers; interrupts leave second
// - 16-bit program counter from low, high bytes
// - 8-bit flags; reset bits 7,6,5,3 one
// - Half carry from bit 3 on add
// - Negative flag copies result bit 7
// - Zero flag set on zero result
// - Carry from arithmetic, set/reset, test, shifts
// - Priority bits encode software level, 11 disables
// - Interrupt entry loads source priority; instructions change
// - Flags pushable, poppable, individually bit controllable
// - Stack pointer upper byte fixed 01, reset 01ff
// - Push writes then decrements; pop increments first
// - Reset or stack-reset instruction sets low ones
// - Stack pointer low byte loadable by load
// - Stack pointer wraps silently both directions
// - Interrupt pushes low pc byte first, decrementing
// - Call uses two stack bytes, interrupt five
module cpu_core_registers
  import cpu_core_pkg::*;
(
  input  wire logic        sys_clk,                 // CPU clock
  input  wire logic        rst,                     // Synchronous MCU reset
  input  wire logic        op_valid,                // Operation request, one cycle
  input  op_type           op,                      // Operation code
  input  wire logic [7:0]  data_in,                 // Operand or external ALU result
  input  wire logic        carry_in,                // Carry from shifter or bit test
  input  wire logic [15:0] target_addr,             // Jump, call or vector address
  input  wire logic [1:0]  source_priority_setting, // Priority of serviced source
  input  wire logic [7:0]  mem_rdata,               // Stack byte read, same cycle
  output logic      [7:0]  acc,                     // Accumulator
  output logic      [7:0]  index_x,                 // First index register
  output logic      [7:0]  index_y,                 // Second index register
  output logic      [15:0] program_counter,         // Next instruction address
  output logic      [7:0]  condition_flags,         // Flags and priority bits
  output logic      [15:0] stack_pointer,           // Next free stack byte
  output logic      [15:0] mem_addr,                // Stack access address
  output logic      [7:0]  mem_wdata,               // Stack write byte
  output logic             mem_write,               // Stack write strobe
  output logic             mem_read,                // Stack read strobe
  output logic             busy                     // Stack sequence running
);

  state_type state;      // Registered state
  state_type next_state; // Next state

  // Bytes in the frame moved by a stack operation
  function automatic logic [2:0] frame_len(input op_type o);
    unique case (o)
      OP_IRQ_ENTRY, OP_RETURN_FROM_INTERRUPT_INSTR: frame_len = `FRAME_IRQ;
      OP_CALL, OP_RET:       frame_len = `FRAME_CALL;
      default:               frame_len = `FRAME_SINGLE;
    endcase
  endfunction : frame_len

  // Byte to push at each step of a push sequence
  function automatic logic [7:0] push_byte(input state_type s);
    push_byte = s.acc;
    unique case (s.op)
      OP_IRQ_ENTRY: begin
        // Low pc byte first, then the rest of the context
        unique case (s.step)
          3'h0:    push_byte = s.program_counter[7:0];
          3'h1:    push_byte = s.program_counter[15:8];
          3'h2:    push_byte = s.index_x;
          3'h3:    push_byte = s.acc;
          default: push_byte = s.condition_flags;
        endcase
      end
      OP_CALL: begin
        // Return address, low byte first
        push_byte = (s.step == 3'h0) ? s.program_counter[7:0] : s.program_counter[15:8];
      end
      OP_PUSH_X:  push_byte = s.index_x;
      OP_PUSH_Y:  push_byte = s.index_y;
      OP_PUSH_CC: push_byte = s.condition_flags;
      default:    push_byte = s.acc;
    endcase
  endfunction : push_byte

  // Negative and zero flags from a result byte
  function automatic logic [7:0] set_nz(input logic [7:0] cc, input logic [7:0] r);
    set_nz = cc;
    set_nz[`FLAG_NEGATIVE] = r[7];
    set_nz[`FLAG_ZERO]     = (r == 8'h00);
  endfunction : set_nz

  // Operation decode and stack sequencing
  always_comb begin
    logic [8:0] sum;       // Add or subtract result with carry
    logic [4:0] low_sum;   // Low nibble sum for half carry
    logic       cin;       // Carry into the adder
    logic [7:0] sp_low;    // Working low stack byte
    next_state           = state;
    next_state.mem_write = 1'b0;
    next_state.mem_read  = 1'b0;
    sum                  = 9'h000;
    low_sum              = 5'h00;
    cin                  = 1'b0;
    sp_low               = state.stack_pointer[7:0];
    unique case (state.seq)
      SEQ_IDLE: begin
        // Requests are taken only here; busy keeps the sequencer away
        if (op_valid) begin
          unique case (op)
            OP_NONE: begin
            end
            OP_LOAD_A: begin
              next_state.acc             = data_in;
              next_state.condition_flags = set_nz(state.condition_flags, data_in);
            end
            OP_LOAD_X: begin
              next_state.index_x         = data_in;
              next_state.condition_flags = set_nz(state.condition_flags, data_in);
            end
            OP_LOAD_Y: begin
              next_state.index_y         = data_in;
              next_state.condition_flags = set_nz(state.condition_flags, data_in);
            end
            OP_ADD, OP_ADC: begin
              // Adder kept here so the half carry sees the real nibble carry
              cin     = (op == OP_ADC) ? state.condition_flags[`FLAG_CARRY] : 1'b0;
              sum     = {1'b0, state.acc} + {1'b0, data_in} + {8'h00, cin};
              low_sum = {1'b0, state.acc[3:0]} + {1'b0, data_in[3:0]} + {4'h0, cin};
              next_state.acc             = sum[7:0];
              next_state.condition_flags = set_nz(state.condition_flags, sum[7:0]);
              next_state.condition_flags[`FLAG_HALF]  = low_sum[4];
              next_state.condition_flags[`FLAG_CARRY] = sum[8];
            end
            OP_SUB: begin
              // Carry flag holds the borrow
              sum = {1'b0, state.acc} - {1'b0, data_in};
              next_state.acc             = sum[7:0];
              next_state.condition_flags = set_nz(state.condition_flags, sum[7:0]);
              next_state.condition_flags[`FLAG_CARRY] = sum[8];
            end
            OP_SHIFT: begin
              next_state.acc             = data_in;
              next_state.condition_flags = set_nz(state.condition_flags, data_in);
              next_state.condition_flags[`FLAG_CARRY] = carry_in;
            end
            OP_BIT_TEST: begin
              next_state.condition_flags[`FLAG_CARRY] = carry_in;
            end
            OP_SET_CARRY: begin
              next_state.condition_flags[`FLAG_CARRY] = 1'b1;
            end
            OP_RESET_CARRY: begin
              next_state.condition_flags[`FLAG_CARRY] = 1'b0;
            end
            OP_SET_PRIORITY: begin
              // Enable, disable, halt and wait give the level in data_in[1:0]
              next_state.condition_flags[`FLAG_PRIO_HIGH] = data_in[1];
              next_state.condition_flags[`FLAG_PRIO_LOW]  = data_in[0];
            end
            OP_FLAG_BIT: begin
              // data_in[2:0] picks the bit, data_in[3] its value
              if (data_in[2:0] <= `FLAG_PRIO_HIGH) begin
                next_state.condition_flags[data_in[2:0]] = data_in[3];
              end
            end
            OP_JUMP: begin
              next_state.program_counter = target_addr;
            end
            OP_LOAD_SP_LOW: begin
              next_state.stack_pointer = {`SP_HIGH, data_in};
            end
            OP_RESET_SP: begin
              next_state.stack_pointer = {`SP_HIGH, `SP_LOW_RESET};
            end
            OP_PUSH_A, OP_PUSH_X, OP_PUSH_Y, OP_PUSH_CC, OP_CALL, OP_IRQ_ENTRY: begin
              next_state.seq         = SEQ_PUSH;
              next_state.op          = op;
              next_state.step        = 3'h0;
              next_state.jump_target = target_addr;
              next_state.busy        = 1'b1;
            end
            OP_POP_A, OP_POP_X, OP_POP_Y, OP_POP_CC, OP_RET, OP_RETURN_FROM_INTERRUPT_INSTR: begin
              next_state.seq  = SEQ_POP_ISSUE;
              next_state.op   = op;
              next_state.step = 3'h0;
              next_state.busy = 1'b1;
            end
            default: begin
            end
          endcase
        end
      end
      SEQ_PUSH: begin
        // Write at the free location, then step down; 8-bit wrap is silent
        next_state.mem_addr      = state.stack_pointer;
        next_state.mem_wdata     = push_byte(state);
        next_state.mem_write     = 1'b1;
        sp_low                   = state.stack_pointer[7:0] - 8'h01;
        next_state.stack_pointer = {`SP_HIGH, sp_low};
        next_state.step          = state.step + 3'h1;
        if (state.step + 3'h1 == frame_len(state.op)) begin
          next_state.seq  = SEQ_IDLE;
          next_state.busy = 1'b0;
          if (state.op == OP_IRQ_ENTRY) begin
            // Priority taken after the old flags are saved
            next_state.condition_flags[`FLAG_PRIO_HIGH] = source_priority_setting[1];
            next_state.condition_flags[`FLAG_PRIO_LOW]  = source_priority_setting[0];
            next_state.program_counter = state.jump_target;
          end else if (state.op == OP_CALL) begin
            next_state.program_counter = state.jump_target;
          end
        end
      end
      SEQ_POP_ISSUE: begin
        // Step up first, then read the byte there
        sp_low                   = state.stack_pointer[7:0] + 8'h01;
        next_state.stack_pointer = {`SP_HIGH, sp_low};
        next_state.mem_addr      = {`SP_HIGH, sp_low};
        next_state.mem_read      = 1'b1;
        next_state.seq           = SEQ_POP_TAKE;
      end
      SEQ_POP_TAKE: begin
        // The byte is on mem_rdata while mem_read is high
        unique case (state.op)
          OP_POP_A: next_state.acc     = mem_rdata;
          OP_POP_X: next_state.index_x = mem_rdata;
          OP_POP_Y: next_state.index_y = mem_rdata;
          OP_POP_CC: begin
            next_state.condition_flags = mem_rdata | `CC_FIXED_ONES;
          end
          OP_RET: begin
            if (state.step == 3'h0) begin
              next_state.program_counter[15:8] = mem_rdata;
            end else begin
              next_state.program_counter[7:0]  = mem_rdata;
            end
          end
          OP_RETURN_FROM_INTERRUPT_INSTR: begin
            // Reverse of the entry order; index_y is never touched
            unique case (state.step)
              3'h0:    next_state.condition_flags       = mem_rdata | `CC_FIXED_ONES;
              3'h1:    next_state.acc                   = mem_rdata;
              3'h2:    next_state.index_x               = mem_rdata;
              3'h3:    next_state.program_counter[15:8] = mem_rdata;
              default: next_state.program_counter[7:0]  = mem_rdata;
            endcase
          end
          default: begin
          end
        endcase
        next_state.step = state.step + 3'h1;
        if (state.step + 3'h1 == frame_len(state.op)) begin
          next_state.seq  = SEQ_IDLE;
          next_state.busy = 1'b0;
        end else begin
          next_state.seq  = SEQ_POP_ISSUE;
        end
      end
      default: begin
        next_state.seq = SEQ_IDLE;
      end
    endcase
    // Upper flag bits and upper stack byte are held by hardware
    next_state.condition_flags = next_state.condition_flags | `CC_FIXED_ONES;
    next_state.stack_pointer[15:8] = `SP_HIGH;
  end

  // State register; reset leaves the flags at 111x1xxx with x as zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state                 <= '0;
      state.acc             <= `ACC_RESET;
      state.index_x         <= `INDEX_RESET;
      state.index_y         <= `INDEX_RESET;
      state.program_counter <= `PC_RESET;
      state.condition_flags <= `CC_RESET;
      state.stack_pointer   <= `SP_RESET;
      state.seq             <= SEQ_IDLE;
      state.op              <= OP_NONE;
    end else begin
      state <= next_state;
    end
  end

  // Outputs straight from the state register
  assign acc             = state.acc;
  assign index_x         = state.index_x;
  assign index_y         = state.index_y;
  assign program_counter = state.program_counter;
  assign condition_flags = state.condition_flags;
  assign stack_pointer   = state.stack_pointer;
  assign mem_addr        = state.mem_addr;
  assign mem_wdata       = state.mem_wdata;
  assign mem_write       = state.mem_write;
  assign mem_read        = state.mem_read;
  assign busy            = state.busy;

endmodule : cpu_core_registers
